// ==== move_exec_pkg.sv ====
// package for the data-move instruction group executor
// assumes a 16-bit instruction word presented one per machine cycle
package move_exec_pkg;

    localparam int INSTR_W = 16;
    localparam int DADDR_W = 7;
    localparam int LADDR_W = 5;
    localparam int NIB_W   = 4;

    // opcode prefixes, matched against the top bits of the word
    localparam logic [7:0] OP_TIMER_A_SET  = 8'h10;
    localparam logic [7:0] OP_TIMER_B_SET  = 8'h11;
    localparam logic [8:0] OP_A_RELOAD_LO  = 9'h022;
    localparam logic [8:0] OP_A_RELOAD_HI  = 9'h029;
    localparam logic [8:0] OP_B_RELOAD_LO  = 9'h02A;
    localparam logic [8:0] OP_B_RELOAD_HI  = 9'h02B;
    localparam logic [6:0] OP_LCD_TO_WR    = 7'h23;
    localparam logic [4:0] OP_MEM_TO_WR    = 5'h1D;
    localparam logic [4:0] OP_IND_READ     = 5'h19;
    localparam logic [4:0] OP_IND_WRITE    = 5'h1B;
    localparam logic [8:0] OP_PAGE_LOAD    = 9'h0BD;
    localparam logic [8:0] OP_CARRY_READ   = 9'h0B2;
    localparam logic [8:0] OP_HOLD_UPPER   = 9'h093;

    // working registers sit at the bottom of data memory
    localparam logic [2:0] WR_PAGE         = 3'h0;
    localparam logic [3:0] PAGE_RESET      = 4'h0;
    localparam logic [7:0] TIMER_RESET     = 8'h00;
    localparam logic [3:0] NIB_ZERO        = 4'h0;

    // data-memory port bundle
    typedef struct packed {
        logic               we;
        logic [DADDR_W-1:0] waddr;
        logic [NIB_W-1:0]   wdata;
    } mem_wr_t;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b01,
        ST_IND   = 2'b10
    } exec_state_t;

endpackage

// ==== move_exec.sv ====
// executor for timer, lcd, page and memory move instructions
// decodes one 16-bit word per machine cycle; indirect moves take two
// assumes an asynchronous-read data memory and lcd ram outside
// assumes the core flags and hold causes come from logic on this clock
// assumes the core applies mem_wr one cycle after the decode cycle
// Overview of operation
// RULE_01 - prefix 00010000 loads an immediate into timer a and starts it.
// RULE_02 - prefix 00010001 loads an immediate into timer b and starts it.
// RULE_03 - opcode 000100010 copies the addressed nibble to timer a reload low.
// RULE_04 - opcode 000101001 copies the addressed nibble to timer a reload high.
// RULE_05 - opcode 000101010 copies the addressed nibble to timer b reload low.
// RULE_06 - opcode 000101011 copies the addressed nibble to timer b reload high.
// RULE_07 - prefix 0100011 copies an lcd ram nibble into a working register.
// RULE_08 - direct operands address data memory through the low seven bits.
// RULE_09 - prefix 11101 copies the addressed nibble into a working register.
// RULE_10 - prefix 11001 reads page*10h plus operand in two cycles.
// RULE_11 - prefix 11011 writes a working register to page*10h plus operand.
// RULE_12 - opcode 010111101 loads the addressed nibble into the page register.
// RULE_13 - carry read puts the carry in bit 0 of accumulator and memory.
// RULE_14 - hold cause read loads both; bit 0 is the divider or pin cause.
// RULE_15 - bit 1 of the hold cause read is the timer b underflow cause.
// RULE_16 - reserved hold cause bits read zero; zero flag follows the value.
`timescale 1ns/1ns
module move_exec
    import move_exec_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // instruction stream
    input  wire logic                 instr_valid,
    input  wire logic [INSTR_W-1:0]   instr,
    output logic                      instr_ready,
    // data memory
    output logic [DADDR_W-1:0]        mem_raddr,
    input  wire logic [NIB_W-1:0]     mem_rdata,
    output mem_wr_t                   mem_wr,
    // lcd ram
    output logic [LADDR_W-1:0]        lcd_raddr,
    input  wire logic [NIB_W-1:0]     lcd_ram_nibble,
    // core flags and hold causes
    input  wire logic                 carry_flag,
    input  wire logic                 hold_cause_div_or_pin,
    input  wire logic                 hold_cause_timer_b,
    // timers
    output logic [7:0]                timer_a_load,
    output logic                      timer_a_start,
    output logic [7:0]                timer_b_load,
    output logic                      timer_b_start,
    output logic [NIB_W-1:0]          timer_a_reload_low,
    output logic [NIB_W-1:0]          timer_a_reload_high,
    output logic [NIB_W-1:0]          timer_b_reload_low,
    output logic [NIB_W-1:0]          timer_b_reload_high,
    // core state
    output logic [NIB_W-1:0]          page_reg,
    output logic [NIB_W-1:0]          accumulator,
    output logic                      zero_flag
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    exec_state_t state_q;
    exec_state_t state_d;
    logic [INSTR_W-1:0]    ind_instr_q;
    logic [DADDR_W-1:0]    ind_addr_q;

    // instruction fields; prefix widths follow the opcode families
    wire [7:0]         op8      = instr[15:8];
    wire [8:0]         op9      = instr[15:7];
    wire [6:0]         op7      = instr[15:9];
    wire [4:0]         op5      = instr[15:11];
    wire [7:0]         imm      = instr[7:0];
    wire [DADDR_W-1:0] dir_addr = instr[DADDR_W-1:0];         // RULE_08
    wire [3:0]         wr_sel   = instr[10:7];
    wire [3:0]         lcd_wsel = instr[3:0];
    wire               in_fetch = (state_q == ST_FETCH);
    wire               go       = instr_valid && in_fetch;

    // timer immediates
    wire dec_ta_set  = go && (op8 == OP_TIMER_A_SET);
    wire dec_tb_set  = go && (op8 == OP_TIMER_B_SET);

    // reload nibbles; the timer a reload low code shares its top byte with
    // the timer b set prefix, so that word both starts timer b and loads
    // the reload nibble, which is what the two codes together ask for
    wire dec_ta_lo   = go && (op9 == OP_A_RELOAD_LO);
    wire dec_ta_hi   = go && (op9 == OP_A_RELOAD_HI);
    wire dec_tb_lo   = go && (op9 == OP_B_RELOAD_LO);
    wire dec_tb_hi   = go && (op9 == OP_B_RELOAD_HI);

    // working register moves
    wire dec_lcd     = go && (op7 == OP_LCD_TO_WR);
    wire dec_mem_wr  = go && (op5 == OP_MEM_TO_WR);
    wire dec_ind_rd  = go && (op5 == OP_IND_READ);
    wire dec_ind_wr  = go && (op5 == OP_IND_WRITE);

    // page load, carry read and hold cause read
    wire dec_page    = go && (op9 == OP_PAGE_LOAD);
    wire dec_carry   = go && (op9 == OP_CARRY_READ);
    wire dec_hold    = go && (op9 == OP_HOLD_UPPER);

    ////////////////////////////////////////////////////////////////////////
    // indirect address: page bits 2..0 select a 16-nibble bank

    wire [DADDR_W-1:0] ind_addr = {page_reg[2:0], mem_rdata};     // RULE_10

    wire [NIB_W-1:0] carry_nib = {3'b000, carry_flag};             // RULE_13
    wire [NIB_W-1:0] hold_nib  = {2'b00, hold_cause_timer_b,       // RULE_15
                                  hold_cause_div_or_pin};          // RULE_14

    ////////////////////////////////////////////////////////////////////////
    // second cycle of an indirect move

    // the second cycle reads the target nibble for a read, or the working
    // register for a write; the pointer was latched in the first cycle
    wire               in_ind      = (state_q == ST_IND);
    wire               ind_is_read = (ind_instr_q[15:11] == OP_IND_READ);
    wire [3:0]         ind_wsel    = ind_instr_q[10:7];
    wire               sel_ind_rd  = in_ind && ind_is_read;
    wire               sel_ind_wr  = in_ind && !ind_is_read;
    wire [DADDR_W-1:0] wreg_addr   = {WR_PAGE, ind_wsel};

    ////////////////////////////////////////////////////////////////////////
    // read ports

    assign instr_ready = in_fetch;
    assign lcd_raddr   = instr[8:4];                           // RULE_07
    // the port serves the direct operand except in an indirect second cycle
    assign mem_raddr   = sel_ind_rd ? ind_addr_q :             // RULE_10
                         sel_ind_wr ? wreg_addr  :             // RULE_11
                                      dir_addr;

    // only the indirect moves need a second cycle; every other code retires
    // in the cycle it is taken, so fetch is the common state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_FETCH: if (dec_ind_rd || dec_ind_wr) state_d = ST_IND;
            ST_IND:   state_d = ST_FETCH;
            default:  state_d = ST_FETCH;
        endcase
    end

    // data-memory write selection, one write per cycle at most
    mem_wr_t wr_d;
    always_comb begin
        wr_d.we    = 1'b0;
        wr_d.waddr = dir_addr;
        wr_d.wdata = NIB_ZERO;
        if (in_ind && ind_is_read) begin
            wr_d.we    = 1'b1;
            wr_d.waddr = {WR_PAGE, ind_wsel};                      // RULE_10
            wr_d.wdata = mem_rdata;
        end else if (in_ind) begin
            wr_d.we    = 1'b1;
            wr_d.waddr = ind_addr_q;                               // RULE_11
            wr_d.wdata = mem_rdata;
        end else if (dec_lcd) begin
            wr_d.we    = 1'b1;
            wr_d.waddr = {WR_PAGE, lcd_wsel};                      // RULE_07
            wr_d.wdata = lcd_ram_nibble;
        end else if (dec_mem_wr) begin
            wr_d.we    = 1'b1;
            wr_d.waddr = {WR_PAGE, wr_sel};                        // RULE_09
            wr_d.wdata = mem_rdata;
        end else if (dec_carry) begin
            wr_d.we    = 1'b1;
            wr_d.wdata = carry_nib;                                // RULE_13
        end else if (dec_hold) begin
            wr_d.we    = 1'b1;
            wr_d.wdata = hold_nib;                                 // RULE_14
        end
    end

    // accumulator load and the zero flag that tracks it
    wire             acc_we = dec_carry || dec_hold;
    wire [NIB_W-1:0] acc_d  = dec_carry ? carry_nib : hold_nib;

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_FETCH;
        end else begin
            state_q <= state_d;
        end
    end

    // the pointer is formed in the first cycle, while the direct operand
    // is still on the read port; the second cycle needs the port itself
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ind_instr_q <= '0;
            ind_addr_q  <= '0;
        end else if (dec_ind_rd || dec_ind_wr) begin
            ind_instr_q <= instr;
            ind_addr_q  <= ind_addr;                            // RULE_11
        end
    end

    // registered write keeps the memory port free of decode glitches
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_wr <= '0;
        end else begin
            mem_wr <= wr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timers

    // timer a value, held until the next set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_a_load <= TIMER_RESET;
        end else if (dec_ta_set) begin
            timer_a_load <= imm;                                   // RULE_01
        end
    end

    // start pulse rises on the same edge as the value it starts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_a_start <= 1'b0;
        end else begin
            timer_a_start <= dec_ta_set;                           // RULE_01
        end
    end

    // timer b value, held until the next set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_b_load <= TIMER_RESET;
        end else if (dec_tb_set) begin
            timer_b_load <= imm;                                   // RULE_02
        end
    end

    // one-cycle pulse; the timer itself keeps counting afterwards
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_b_start <= 1'b0;
        end else begin
            timer_b_start <= dec_tb_set;                           // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reload nibbles, one flop group per timer half

    wire  [3:0]       reload_we;
    logic [NIB_W-1:0] reload_q [4];
    assign reload_we[0] = dec_ta_lo;                               // RULE_03
    assign reload_we[1] = dec_ta_hi;                               // RULE_04
    assign reload_we[2] = dec_tb_lo;                               // RULE_05
    assign reload_we[3] = dec_tb_hi;                               // RULE_06

    for (genvar g = 0; g < 4; g++) begin : g_reload
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                reload_q[g] <= NIB_ZERO;
            end else if (reload_we[g]) begin
                reload_q[g] <= mem_rdata;
            end
        end
    end

    assign timer_a_reload_low  = reload_q[0];
    assign timer_a_reload_high = reload_q[1];
    assign timer_b_reload_low  = reload_q[2];
    assign timer_b_reload_high = reload_q[3];

    ////////////////////////////////////////////////////////////////////////
    // page register, accumulator and zero flag

    // all four page bits are kept, only the low three form the pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            page_reg <= PAGE_RESET;
        end else if (dec_page) begin
            page_reg <= mem_rdata;                                 // RULE_12
        end
    end

    // only the carry and hold cause reads of this group touch it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accumulator <= NIB_ZERO;
        end else if (acc_we) begin
            accumulator <= acc_d;                                  // RULE_13
        end
    end

    // set out of reset to match the cleared accumulator
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            zero_flag <= 1'b1;
        end else if (acc_we) begin
            zero_flag <= (acc_d == NIB_ZERO);                      // RULE_16
        end
    end

endmodule // move_exec

// ==== move_exec_checker.sv ====
// checker for the move executor, watching its ports only
// assumes one clock domain with the synchronous active-low reset
`timescale 1ns/1ns
module move_exec_checker
    import move_exec_pkg::*;
(
    // clock, reset and instruction stream
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               instr_valid,
    input wire logic               instr_ready,
    input wire logic [INSTR_W-1:0] instr,
    // memories
    input wire logic [DADDR_W-1:0] mem_raddr,
    input wire logic [NIB_W-1:0]   mem_rdata,
    input wire logic [NIB_W-1:0]   lcd_ram_nibble,
    input wire mem_wr_t            mem_wr,
    input wire logic [LADDR_W-1:0] lcd_raddr,
    // flags and results
    input wire logic               carry_flag,
    input wire logic               hold_cause_div_or_pin,
    input wire logic               hold_cause_timer_b,
    input wire logic               timer_a_start,
    input wire logic [7:0]         timer_a_load,
    input wire logic [7:0]         timer_b_load,
    input wire logic [NIB_W-1:0]   timer_a_reload_low,
    input wire logic [NIB_W-1:0]   page_reg,
    input wire logic [NIB_W-1:0]   accumulator,
    input wire logic               timer_b_start,
    input wire logic               zero_flag
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take = instr_valid && instr_ready;

    chk_timer_a_set: assert property (
        take && instr[15:8] == OP_TIMER_A_SET |=> timer_a_start
        && timer_a_load == $past(instr[7:0])) else $error("timer a set");
    chk_start_a_cause: assert property (
        !(take && instr[15:8] == OP_TIMER_A_SET) |=> !timer_a_start)
        else $error("stray timer a start");
    chk_timer_b_set: assert property (
        take && instr[15:8] == OP_TIMER_B_SET |=> timer_b_start
        && timer_b_load == $past(instr[7:0])) else $error("timer b set");
    chk_reload_a_low: assert property (
        take && instr[15:7] == OP_A_RELOAD_LO
        |=> timer_a_reload_low == $past(mem_rdata)) else $error("reload");
    chk_lcd_move: assert property (
        take && instr[15:9] == OP_LCD_TO_WR |-> lcd_raddr == instr[8:4]
        ##1 mem_wr.we && mem_wr.waddr == {3'b000, $past(instr[3:0])}
        && mem_wr.wdata == $past(lcd_ram_nibble)) else $error("lcd move");
    chk_direct_addr: assert property (
        take && instr[15:11] == OP_MEM_TO_WR |-> mem_raddr == instr[6:0])
        else $error("direct address");
    chk_ind_two_cycles: assert property (
        take && instr[15:11] == OP_IND_READ |=> !instr_ready ##1 instr_ready
        && mem_wr.we && mem_wr.waddr == {3'b000, $past(instr[10:7], 2)})
        else $error("indirect read");
    chk_ind_write_addr: assert property (
        take && instr[15:11] == OP_IND_WRITE |=> ##1 mem_wr.we
        && mem_wr.waddr == {$past(page_reg[2:0], 2), $past(mem_rdata, 2)})
        else $error("indirect write");
    chk_page_load: assert property (
        take && instr[15:7] == OP_PAGE_LOAD |=> page_reg == $past(mem_rdata))
        else $error("page load");
    chk_carry_read: assert property (
        take && instr[15:7] == OP_CARRY_READ
        |=> accumulator == {3'b000, $past(carry_flag)} && mem_wr.we
        && mem_wr.wdata == accumulator) else $error("carry read");
    chk_hold_upper: assert property (
        take && instr[15:7] == OP_HOLD_UPPER |=> zero_flag == (accumulator
        == 4'h0) && accumulator == {2'b00, $past(hold_cause_timer_b),
        $past(hold_cause_div_or_pin)}) else $error("hold cause read");

    cover property (take && instr[15:11] == OP_IND_READ);
    cover property (take && instr[15:11] == OP_IND_WRITE);
    cover property (take && instr[15:7] == OP_HOLD_UPPER);
endmodule // move_exec_checker

bind move_exec move_exec_checker chk_i (.clk, .rst_n, .instr_valid,
    .instr_ready, .instr, .mem_raddr, .mem_rdata, .lcd_ram_nibble, .mem_wr,
    .lcd_raddr, .carry_flag, .hold_cause_div_or_pin, .hold_cause_timer_b,
    .timer_a_start, .timer_a_load, .timer_b_load, .timer_a_reload_low,
    .page_reg, .accumulator, .timer_b_start, .zero_flag);

// ==== move_exec_tb.sv ====
// self-checking testbench for the move executor
// assumes the checker file is compiled alongside
`timescale 1ns/1ns
module move_exec_tb;
    import move_exec_pkg::*;
    logic        clk = 0, rst_n = 0, instr_valid = 0, carry_flag = 0;
    logic        hold_cause_div_or_pin = 0, hold_cause_timer_b = 0;
    logic [15:0] instr = '0;
    logic        instr_ready, timer_a_start, timer_b_start, zero_flag;
    logic [6:0]  mem_raddr;
    logic [4:0]  lcd_raddr;
    logic [3:0]  mem_rdata, lcd_ram_nibble, a_lo, a_hi, b_lo, b_hi, e;
    logic [3:0]  page_reg, accumulator;
    logic [7:0]  timer_a_load, timer_b_load;
    mem_wr_t     mem_wr;
    int          n_mismatch = 0, n_compared = 0, cycles = 0;

    // contents follow the address so every read is predictable
    function automatic logic [3:0] m(input logic [6:0] a);
        return a[3:0] ^ {1'b0, a[6:4]};
    endfunction
    assign mem_rdata = m(mem_raddr);
    assign lcd_ram_nibble = ~lcd_raddr[3:0] ^ {3'b000, lcd_raddr[4]};

    move_exec dut (.clk, .rst_n, .instr_valid, .instr, .instr_ready,
        .mem_raddr, .mem_rdata, .mem_wr, .lcd_raddr, .lcd_ram_nibble,
        .carry_flag, .hold_cause_div_or_pin, .hold_cause_timer_b,
        .timer_a_load, .timer_a_start, .timer_b_load, .timer_b_start,
        .timer_a_reload_low(a_lo), .timer_a_reload_high(a_hi),
        .timer_b_reload_low(b_lo), .timer_b_reload_high(b_hi),
        .page_reg, .accumulator, .zero_flag);

    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle cycle before each issue keeps the handshake simple
    task automatic go(input logic [15:0] w);
        @(posedge clk);
        instr <= w;
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({instr_ready, mem_wr.we, zero_flag, accumulator, page_reg},
            16'h0500);
        go(16'h10A5);
        chk({timer_a_start, mem_wr.we, timer_a_load}, 16'h02A5);
        step();
        chk({timer_a_start, timer_b_start}, 16'h0000);
        go(16'h115A);
        chk({timer_b_start, timer_a_start, timer_b_load}, 16'h025A);
        go({9'h022, 7'h41});
        go({9'h029, 7'h17});
        go({9'h02A, 7'h2C});
        go({9'h02B, 7'h39});
        chk({a_lo, a_hi}, 16'h0056);
        chk({b_lo, b_hi}, 16'h00EA);
        go(16'h4736);
        chk(mem_wr, 16'h086D);
        go(16'hECDB);
        chk(mem_wr, 16'h089E);
        go(16'h5EBC);
        chk(page_reg, 16'h000F);
        go(16'hC9A1);
        chk(instr_ready, 16'h0000);
        step();
        chk({instr_ready, mem_wr}, 16'h1834);
        go(16'hDAA2);
        step();
        chk(mem_wr, 16'h0F05);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            carry_flag <= i[1];
            hold_cause_div_or_pin <= i[1];
            hold_cause_timer_b <= i[2];
            e = i[0] ? {3'b000, i[1]} : {2'b00, i[2], i[1]};
            go(i[0] ? 16'h5911 : 16'h4992);
            chk({zero_flag, accumulator}, {e == 4'h0, e});
            chk(mem_wr, {1'b1, i[0] ? 7'h11 : 7'h12, e});
        end
        // second reset in mid-run, then an instruction right after it
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({instr_ready, zero_flag, accumulator, page_reg}, 16'h0300);
        go(16'h115A);
        chk({timer_b_start, timer_b_load}, 16'h015A);
        results();
    end
endmodule // move_exec_tb
